// ---- logic/mac_table_regs.sv ----
// Register access to the address lookup table and its forwarding lookup
// Functional notes
// - Setting make commits both write words as one entry; hardware picks the slot.
// - Make also modifies or removes an existing entry, manual or learned.
// - Writing zero to make, get-first or get-next does nothing.
// - Get-first restarts at table start and loads first valid entry to read words.
// - Get-next loads the following valid entry into the read words.
// - Make completion is shown by make-pending in the command status register.
// - Write word low holds the first 32 address bits, bit 0 group bit.
// - Valid bit 26 set makes entry valid; cleared invalidates matching entry.
// - Static entry with bit 25 forwards regardless of port state except disabled.
// - Static bit 24 entries never aged out nor changed by learning.
// - Non-static entries removed after 5 to 10 minutes without source match.
// - Filter bit 23 drops packets whose destination matches.
// - Priority enable bit 22 gates use of priority field.
// - Priority bits 21:19 apply only with enable and global destination priority on.
// - Bits 18:16 pick ports: single, reserved 011, pairs, or all three.
// - Bits 15:0 of write word high hold last 16 address bits.
module mac_table_regs import mac_table_pkg::*; #(
    parameter longint unsigned AGE_PERIOD_CYCLES = AGE_PERIOD_DEFAULT
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Register port
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    // Source learning
    input wire logic LEARN_VALID_IN,
    input wire logic [47:0] LEARN_ADDR_IN,
    input wire logic [1:0] LEARN_PORT_IN,
    // Destination lookup
    input wire logic LOOKUP_VALID_IN,
    input wire logic [47:0] LOOKUP_ADDR_IN,
    input wire logic DA_HIGHEST_PRIO_IN,
    output logic LOOKUP_DONE_OUT,
    output logic LOOKUP_HIT_OUT,
    output logic LOOKUP_DROP_OUT,
    output logic LOOKUP_OVERRIDE_OUT,
    output logic LOOKUP_PRIO_VALID_OUT,
    output logic [2:0] LOOKUP_PRIO_OUT,
    output logic [2:0] LOOKUP_PORTS_OUT
);
    table_if tif ();

    ctrl_state_t state_q, state_d;
    logic [2:0] cmd_q, cmd_d;
    logic [31:0] wr_low_q, wr_low_d;
    logic [26:0] wr_high_q, wr_high_d;
    entry_t rd_entry_q, rd_entry_d;
    logic found_q, found_d;
    logic eot_q, eot_d;
    logic make_pend_q, make_pend_d;
    logic [IDX_W:0] ptr_q, ptr_d;
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] age_cnt_q, age_cnt_d;
    logic age_tick_q, age_tick_d;
    logic look_hit;
    entry_t look_entry;
    logic wr_cmd;
    logic set_make, set_first, set_next;

    lookup_table_store u_store (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .tif(tif.store),
        .learn_valid_in(LEARN_VALID_IN),
        .learn_addr_in(LEARN_ADDR_IN),
        .learn_port_in(LEARN_PORT_IN),
        .age_tick_in(age_tick_q),
        .lookup_addr_in(LOOKUP_ADDR_IN),
        .lookup_hit_out(look_hit),
        .lookup_entry_out(look_entry)
    );

    // Entry built from the two write words
    assign tif.make_req = (state_q == ST_MAKE);
    assign tif.make_entry.addr = {wr_high_q[W_ADDR_MSB:0], wr_low_q};
    assign tif.make_entry.valid = wr_high_q[W_VALID_BIT];
    assign tif.make_entry.age = wr_high_q[W_AGE_BIT];
    assign tif.make_entry.stat = wr_high_q[W_STATIC_BIT];
    assign tif.make_entry.filt = wr_high_q[W_FILTER_BIT];
    assign tif.make_entry.pen = wr_high_q[W_PEN_BIT];
    assign tif.make_entry.prio = wr_high_q[W_PRIO_MSB:W_PRIO_LSB];
    assign tif.make_entry.ports = wr_high_q[W_PORT_MSB:W_PORT_LSB];
    assign tif.rd_idx = ptr_q[IDX_W-1:0];

    // Command decode: only a written one starts an action
    assign wr_cmd = REG_WR_IN && (REG_ADDR_IN == CMD_OFS);
    assign set_make = wr_cmd && REG_WDATA_IN[CMD_MAKE_BIT];
    assign set_first = wr_cmd && REG_WDATA_IN[CMD_FIRST_BIT];
    assign set_next = wr_cmd && REG_WDATA_IN[CMD_NEXT_BIT];

    // Register writes, command sequencing and table walk
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        wr_low_d = wr_low_q;
        wr_high_d = wr_high_q;
        rd_entry_d = rd_entry_q;
        found_d = found_q;
        eot_d = eot_q;
        make_pend_d = make_pend_q;
        ptr_d = ptr_q;
        if (wr_cmd) begin
            cmd_d = REG_WDATA_IN[2:0];
        end
        if (REG_WR_IN && REG_ADDR_IN == WR_LOW_OFS) begin
            wr_low_d = REG_WDATA_IN;
        end
        if (REG_WR_IN && REG_ADDR_IN == WR_HIGH_OFS) begin
            wr_high_d = REG_WDATA_IN[26:0];
        end
        case (state_q)
            ST_IDLE: begin
                if (set_make) begin
                    make_pend_d = 1'b1;
                    state_d = ST_MAKE;
                end else if (set_first) begin
                    ptr_d = '0;
                    found_d = 1'b0;
                    eot_d = 1'b0;
                    state_d = ST_SEARCH;
                end else if (set_next) begin
                    found_d = 1'b0;
                    eot_d = 1'b0;
                    state_d = ST_SEARCH;
                end
            end
            ST_MAKE: begin
                // Store commits on this edge
                make_pend_d = 1'b0;
                state_d = ST_IDLE;
            end
            ST_SEARCH: begin
                if (ptr_q == (IDX_W + 1)'(TABLE_DEPTH)) begin
                    eot_d = 1'b1;
                    state_d = ST_IDLE;
                end else if (tif.rd_entry.valid) begin
                    rd_entry_d = tif.rd_entry;
                    found_d = 1'b1;
                    eot_d = (ptr_q == (IDX_W + 1)'(TABLE_DEPTH - 1));
                    ptr_d = ptr_q + 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    ptr_d = ptr_q + 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Register read port, one cycle latency
    always_comb begin
        rvalid_d = REG_RD_IN;
        rdata_d = rdata_q;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                CMD_OFS: rdata_d = {29'h0000_0000, cmd_q};
                WR_LOW_OFS: rdata_d = wr_low_q;
                WR_HIGH_OFS: rdata_d = {5'h00, wr_high_q};
                RD_LOW_OFS: rdata_d = rd_entry_q.addr[31:0];
                RD_HIGH_OFS: rdata_d = {5'h00, found_q, eot_q, rd_entry_q.stat,
                    rd_entry_q.filt, rd_entry_q.pen, rd_entry_q.prio,
                    rd_entry_q.ports, rd_entry_q.addr[47:32]};
                STS_OFS: rdata_d = {30'h0000_0000, state_q == ST_SEARCH, make_pend_q};
                default: rdata_d = ZERO_WORD;
            endcase
        end
    end

    // Aging sweep timer
    always_comb begin
        age_tick_d = 1'b0;
        age_cnt_d = age_cnt_q + 32'h0000_0001;
        if (age_cnt_q >= 32'(AGE_PERIOD_CYCLES - 64'd1)) begin
            age_cnt_d = 32'h0000_0000;
            age_tick_d = 1'b1;
        end
    end

    // Control and register state
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_RESET;
            wr_low_q <= WR_LOW_RESET;
            wr_high_q <= WR_HIGH_RESET;
            rd_entry_q <= '0;
            found_q <= 1'b0;
            eot_q <= 1'b0;
            make_pend_q <= 1'b0;
            ptr_q <= '0;
            rdata_q <= ZERO_WORD;
            rvalid_q <= 1'b0;
            age_cnt_q <= 32'h0000_0000;
            age_tick_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            wr_low_q <= wr_low_d;
            wr_high_q <= wr_high_d;
            rd_entry_q <= rd_entry_d;
            found_q <= found_d;
            eot_q <= eot_d;
            make_pend_q <= make_pend_d;
            ptr_q <= ptr_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            age_cnt_q <= age_cnt_d;
            age_tick_q <= age_tick_d;
        end
    end

    // Destination lookup results, registered
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            LOOKUP_DONE_OUT <= 1'b0;
            LOOKUP_HIT_OUT <= 1'b0;
            LOOKUP_DROP_OUT <= 1'b0;
            LOOKUP_OVERRIDE_OUT <= 1'b0;
            LOOKUP_PRIO_VALID_OUT <= 1'b0;
            LOOKUP_PRIO_OUT <= 3'h0;
            LOOKUP_PORTS_OUT <= 3'h0;
        end else begin
            LOOKUP_DONE_OUT <= LOOKUP_VALID_IN;
            LOOKUP_HIT_OUT <= look_hit;
            LOOKUP_DROP_OUT <= look_hit && look_entry.filt;
            LOOKUP_OVERRIDE_OUT <= look_hit && look_entry.stat && look_entry.age;
            LOOKUP_PRIO_VALID_OUT <= look_hit && look_entry.pen && DA_HIGHEST_PRIO_IN;
            LOOKUP_PRIO_OUT <= (look_hit && look_entry.pen && DA_HIGHEST_PRIO_IN)
                ? look_entry.prio : 3'h0;
            LOOKUP_PORTS_OUT <= look_hit ? port_mask(look_entry.ports) : 3'h0;
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign REG_RVALID_OUT = rvalid_q;

endmodule // mac_table_regs

// ---- logic/mac_table_pkg.sv ----
// Constants, field layout and types for the address lookup table access block
package mac_table_pkg;

    // Register numbers (word index on the register port)
    localparam logic [15:0] CMD_OFS = 16'h1800;
    localparam logic [15:0] WR_LOW_OFS = 16'h1801;
    localparam logic [15:0] WR_HIGH_OFS = 16'h1802;
    localparam logic [15:0] RD_LOW_OFS = 16'h1805;
    localparam logic [15:0] RD_HIGH_OFS = 16'h1806;
    localparam logic [15:0] STS_OFS = 16'h1808;

    // Command bits
    localparam int CMD_MAKE_BIT = 2;
    localparam int CMD_FIRST_BIT = 1;
    localparam int CMD_NEXT_BIT = 0;

    // Entry word high layout
    localparam int W_VALID_BIT = 26;
    localparam int W_AGE_BIT = 25;
    localparam int W_STATIC_BIT = 24;
    localparam int W_FILTER_BIT = 23;
    localparam int W_PEN_BIT = 22;
    localparam int W_PRIO_MSB = 21;
    localparam int W_PRIO_LSB = 19;
    localparam int W_PORT_MSB = 18;
    localparam int W_PORT_LSB = 16;
    localparam int W_ADDR_MSB = 15;

    // Read word high flags and status bits
    localparam int R_FOUND_BIT = 26;
    localparam int R_EOT_BIT = 25;
    localparam int STS_MAKE_PEND_BIT = 0;
    localparam int STS_SEARCH_BUSY_BIT = 1;

    // Reset values and zero word
    localparam logic [2:0] CMD_RESET = 3'h0;
    localparam logic [31:0] WR_LOW_RESET = 32'h0000_0000;
    localparam logic [26:0] WR_HIGH_RESET = 27'h000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Table geometry
    localparam int TABLE_DEPTH = 16;
    localparam int IDX_W = $clog2(TABLE_DEPTH);

    // Aging: one sweep per least inactivity time, removal after two sweeps
    localparam longint unsigned CLK_HZ = 64'd10_000_000;
    localparam longint unsigned AGE_MIN_MINUTES = 64'd5;
    localparam longint unsigned AGE_PERIOD_DEFAULT = AGE_MIN_MINUTES * 64'd60 * CLK_HZ;

    typedef struct packed {
        logic [47:0] addr;
        logic valid;
        logic age;
        logic stat;
        logic filt;
        logic pen;
        logic [2:0] prio;
        logic [2:0] ports;
    } entry_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MAKE = 2'b01,
        ST_SEARCH = 2'b10
    } ctrl_state_t;

    // Port code to member mask; the reserved code selects nothing
    function automatic logic [2:0] port_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            3'b000: m = 3'b001;
            3'b001: m = 3'b010;
            3'b010: m = 3'b100;
            3'b100: m = 3'b011;
            3'b101: m = 3'b101;
            3'b110: m = 3'b110;
            3'b111: m = 3'b111;
            default: m = 3'b000;
        endcase
        return m;
    endfunction

endpackage

// ---- logic/table_if.sv ----
// Link between the register controller and the table storage
interface table_if import mac_table_pkg::*; ();
    logic make_req;
    entry_t make_entry;
    logic [IDX_W-1:0] rd_idx;
    entry_t rd_entry;

    modport store (input make_req, input make_entry, input rd_idx, output rd_entry);
    modport ctrl (output make_req, output make_entry, output rd_idx, input rd_entry);
endinterface

// ---- logic/lookup_table_store.sv ----
// Table storage with make, learning, aging and destination lookup
module lookup_table_store import mac_table_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Controller side
    table_if.store tif,
    // Learning and aging
    input wire logic learn_valid_in,
    input wire logic [47:0] learn_addr_in,
    input wire logic [1:0] learn_port_in,
    input wire logic age_tick_in,
    // Destination lookup
    input wire logic [47:0] lookup_addr_in,
    output logic lookup_hit_out,
    output entry_t lookup_entry_out
);
    entry_t entry_q [TABLE_DEPTH];
    entry_t entry_d [TABLE_DEPTH];
    logic [TABLE_DEPTH-1:0] make_match;
    logic [TABLE_DEPTH-1:0] learn_match;
    logic [TABLE_DEPTH-1:0] look_match;
    logic [TABLE_DEPTH-1:0] free_v;
    logic [TABLE_DEPTH-1:0] make_sel;
    logic [TABLE_DEPTH-1:0] learn_sel;
    logic learn_new;

    // Slot selection: matching entry first, else first free slot
    always_comb begin
        logic taken;
        taken = 1'b0;
        make_sel = '0;
        learn_sel = '0;
        learn_new = 1'b0;
        lookup_hit_out = 1'b0;
        lookup_entry_out = '0;
        if (tif.make_req) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                if (make_match[i] && !taken) begin
                    make_sel[i] = 1'b1;
                    taken = 1'b1;
                end
            end
            // Clearing valid only removes a match, never allocates
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                if (free_v[i] && !taken && tif.make_entry.valid) begin
                    make_sel[i] = 1'b1;
                    taken = 1'b1;
                end
            end
        end else if (learn_valid_in) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                if (learn_match[i] && !taken) begin
                    learn_sel[i] = !entry_q[i].stat;
                    taken = 1'b1;
                end
            end
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                if (free_v[i] && !taken) begin
                    learn_sel[i] = 1'b1;
                    learn_new = 1'b1;
                    taken = 1'b1;
                end
            end
        end
        for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
            if (look_match[i]) begin
                lookup_hit_out = 1'b1;
                lookup_entry_out = entry_q[i];
            end
        end
    end

    assign tif.rd_entry = entry_q[tif.rd_idx];

    // Per entry compare and update
    for (genvar i = 0; i < TABLE_DEPTH; i++) begin : g_entry
        assign make_match[i] = entry_q[i].valid && entry_q[i].addr == tif.make_entry.addr;
        assign learn_match[i] = entry_q[i].valid && entry_q[i].addr == learn_addr_in;
        assign look_match[i] = entry_q[i].valid && entry_q[i].addr == lookup_addr_in;
        assign free_v[i] = !entry_q[i].valid;

        always_comb begin
            entry_d[i] = entry_q[i];
            if (make_sel[i]) begin
                entry_d[i] = tif.make_entry;
            end else if (learn_sel[i]) begin
                entry_d[i].valid = 1'b1;
                entry_d[i].age = 1'b1;
                entry_d[i].addr = learn_addr_in;
                entry_d[i].ports = {1'b0, learn_port_in};
                if (learn_new) begin
                    entry_d[i].stat = 1'b0;
                    entry_d[i].filt = 1'b0;
                    entry_d[i].pen = 1'b0;
                    entry_d[i].prio = 3'h0;
                end
            end else if (age_tick_in && entry_q[i].valid && !entry_q[i].stat) begin
                // Seen since last sweep: mark stale, else remove
                if (entry_q[i].age) begin
                    entry_d[i].age = 1'b0;
                end else begin
                    entry_d[i].valid = 1'b0;
                end
            end
        end

        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                entry_q[i] <= '0;
            end else begin
                entry_q[i] <= entry_d[i];
            end
        end
    end

endmodule // lookup_table_store

// ---- test/mac_table_regs_assertions.sv ----
// Concurrent checks on the register and lookup ports of the table block
module mac_table_regs_assertions import mac_table_pkg::*; #(
    parameter longint unsigned AGE_PERIOD_CYCLES = AGE_PERIOD_DEFAULT
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Register port
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    input wire logic REG_RVALID_OUT,
    // Destination lookup
    input wire logic DA_HIGHEST_PRIO_IN,
    input wire logic LOOKUP_HIT_OUT,
    input wire logic LOOKUP_DROP_OUT,
    input wire logic LOOKUP_OVERRIDE_OUT,
    input wire logic LOOKUP_PRIO_VALID_OUT,
    input wire logic [2:0] LOOKUP_PRIO_OUT,
    input wire logic [2:0] LOOKUP_PORTS_OUT
);
    // One clock domain, checks idle during reset
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // Write then read of the low write word on consecutive edges
    sequence low_wr_rd_s;
        REG_WR_IN && !REG_RD_IN && REG_ADDR_IN == WR_LOW_OFS ##1
        REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == WR_LOW_OFS;
    endsequence

    // Register port answers
    read_valid_a: assert property (REG_RVALID_OUT == $past(REG_RD_IN))
        else $error("read valid not one edge after read strobe");
    low_readback_a: assert property (
        low_wr_rd_s |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
        else $error("low write word does not read back");
    high_reserved_a: assert property (
        REG_RD_IN && REG_ADDR_IN == WR_HIGH_OFS |=> REG_RDATA_OUT[31:27] == 5'h00)
        else $error("high write word reserved bits not zero");

    // Lookup result consistency
    drop_hit_a: assert property (LOOKUP_DROP_OUT |-> LOOKUP_HIT_OUT)
        else $error("drop without hit");
    override_hit_a: assert property (LOOKUP_OVERRIDE_OUT |-> LOOKUP_HIT_OUT)
        else $error("override without hit");
    prio_gate_a: assert property (
        LOOKUP_PRIO_VALID_OUT |-> LOOKUP_HIT_OUT && $past(DA_HIGHEST_PRIO_IN))
        else $error("priority used without hit or global enable");
    prio_idle_a: assert property (!LOOKUP_PRIO_VALID_OUT |-> LOOKUP_PRIO_OUT == 3'h0)
        else $error("priority shown while not enabled");
    miss_ports_a: assert property (!LOOKUP_HIT_OUT |-> LOOKUP_PORTS_OUT == 3'h0)
        else $error("ports shown on a miss");

    // Main scenarios reached
    cover property (REG_WR_IN && REG_ADDR_IN == CMD_OFS && REG_WDATA_IN[CMD_MAKE_BIT]);
    cover property (LOOKUP_DROP_OUT);
    cover property (LOOKUP_PRIO_VALID_OUT);
    cover property (low_wr_rd_s);
endmodule // mac_table_regs_assertions

bind mac_table_regs mac_table_regs_assertions #(.AGE_PERIOD_CYCLES(AGE_PERIOD_CYCLES)) chk_u (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
    .DA_HIGHEST_PRIO_IN(DA_HIGHEST_PRIO_IN), .LOOKUP_HIT_OUT(LOOKUP_HIT_OUT),
    .LOOKUP_DROP_OUT(LOOKUP_DROP_OUT), .LOOKUP_OVERRIDE_OUT(LOOKUP_OVERRIDE_OUT),
    .LOOKUP_PRIO_VALID_OUT(LOOKUP_PRIO_VALID_OUT), .LOOKUP_PRIO_OUT(LOOKUP_PRIO_OUT),
    .LOOKUP_PORTS_OUT(LOOKUP_PORTS_OUT)
);

// ---- test/test_mac_table_regs.sv ----
// Self-checking bench for the table access register block
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, e, g); end end

module test_mac_table_regs import mac_table_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint unsigned AGE_CYC = 20;
    localparam logic [15:0] RST_ADDRS [7] = '{CMD_OFS, WR_LOW_OFS, WR_HIGH_OFS, RD_LOW_OFS,
        RD_HIGH_OFS, STS_OFS, 16'h1803};
    localparam logic [2:0] PMASK [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
    logic clk = 1'b0;
    logic rst, wr, rd, rvalid, learn_v, lk_v, dahp;
    logic lk_done, lk_hit, lk_drop, lk_ovr, lk_pv;
    logic [15:0] addr;
    logic [31:0] wdata, rdata;
    logic [47:0] learn_a, lk_a;
    logic [1:0] learn_p;
    logic [2:0] lk_prio, lk_ports;
    int error_cnt = 0;
    int checks = 0;

    // Clock, 100 ns period
    always #50 clk = ~clk;

    mac_table_regs #(.AGE_PERIOD_CYCLES(AGE_CYC)) dut_u (
        .CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .LEARN_VALID_IN(learn_v), .LEARN_ADDR_IN(learn_a), .LEARN_PORT_IN(learn_p),
        .LOOKUP_VALID_IN(lk_v), .LOOKUP_ADDR_IN(lk_a), .DA_HIGHEST_PRIO_IN(dahp),
        .LOOKUP_DONE_OUT(lk_done), .LOOKUP_HIT_OUT(lk_hit), .LOOKUP_DROP_OUT(lk_drop),
        .LOOKUP_OVERRIDE_OUT(lk_ovr), .LOOKUP_PRIO_VALID_OUT(lk_pv),
        .LOOKUP_PRIO_OUT(lk_prio), .LOOKUP_PORTS_OUT(lk_ports)
    );

    // High word layout: valid/found, age/end, static, filter, prio-en, prio, port, addr
    function automatic logic [31:0] hi(logic v, logic a, logic s, logic f, logic p,
        logic [2:0] pr, logic [2:0] pc, logic [15:0] ad);
        return {5'h00, v, a, s, f, p, pr, pc, ad};
    endfunction

    // Counts and verdict
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Register port cycles
    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk); addr = a; wdata = d; wr = 1'b1;
        @(negedge clk); wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge clk); addr = a; rd = 1'b1;
        @(negedge clk); rd = 1'b0;
        `CHK("read valid", 1'b1, rvalid)
        d = rdata;
    endtask
    task automatic wr_rd(input logic [15:0] wa, input logic [31:0] d, input logic [15:0] ra,
        output logic [31:0] q);
        @(negedge clk); addr = wa; wdata = d; wr = 1'b1;
        @(negedge clk); wr = 1'b0; addr = ra; rd = 1'b1;
        @(negedge clk); rd = 1'b0;
        q = rdata;
    endtask
    task automatic wait_idle;
        logic [31:0] s;
        for (int i = 0; i < 40; i++) begin
            reg_rd(STS_OFS, s);
            if (s[1:0] === 2'h0) return;
        end
        error_cnt++;
        $display("Error status idle expected 0 seen %h", s);
        test_done();
    endtask

    // Table commands and port-side requests
    task automatic make(input logic [31:0] lo, input logic [31:0] h);
        reg_wr(WR_LOW_OFS, lo);
        reg_wr(WR_HIGH_OFS, h);
        reg_wr(CMD_OFS, 32'h0000_0004);
        wait_idle();
        reg_wr(CMD_OFS, ZERO_WORD);
    endtask
    task automatic cmd_get(input logic [31:0] c, output logic [31:0] lo, output logic [31:0] h);
        reg_wr(CMD_OFS, c);
        wait_idle();
        reg_wr(CMD_OFS, ZERO_WORD);
        reg_rd(RD_LOW_OFS, lo);
        reg_rd(RD_HIGH_OFS, h);
    endtask
    task automatic look(input logic [47:0] a, input logic p, input logic [9:0] e);
        @(negedge clk); lk_a = a; dahp = p; lk_v = 1'b1;
        @(negedge clk); lk_v = 1'b0;
        `CHK("lookup done", 1'b1, lk_done)
        `CHK("lookup result", e, {lk_hit, lk_drop, lk_ovr, lk_pv, lk_prio, lk_ports})
    endtask
    task automatic learn(input logic [47:0] a, input logic [1:0] p);
        @(negedge clk); learn_a = a; learn_p = p; learn_v = 1'b1;
        @(negedge clk); learn_v = 1'b0;
    endtask

    // Reset values, unmapped place, reserved bits, zero command
    task automatic t_regs;
        logic [31:0] q;
        reg_wr(16'h1803, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) begin
            reg_rd(RST_ADDRS[i], q);
            `CHK("reset value", ZERO_WORD, q)
        end
        wr_rd(WR_HIGH_OFS, 32'hFFFF_FFFF, WR_HIGH_OFS, q);
        `CHK("high write word", 32'h07FF_FFFF, q)
        wr_rd(WR_LOW_OFS, 32'h1234_5679, WR_LOW_OFS, q);
        `CHK("low write word", 32'h1234_5679, q)
        wr_rd(CMD_OFS, ZERO_WORD, STS_OFS, q);
        `CHK("status after zero command", ZERO_WORD, q)
    endtask

    // Static override entry with priority, then modify and remove it
    task automatic t_make;
        logic [31:0] q;
        reg_wr(WR_LOW_OFS, 32'h1234_5679);
        reg_wr(WR_HIGH_OFS, hi(1, 1, 1, 0, 1, 3'h5, 3'h5, 16'h5566));
        wr_rd(CMD_OFS, 32'h0000_0004, STS_OFS, q);
        `CHK("make pending", 32'h0000_0001, q)
        wait_idle();
        reg_wr(CMD_OFS, ZERO_WORD);
        look(48'h5566_1234_5679, 1'b1, {4'b1011, 3'h5, 3'h5});
        look(48'h5566_1234_5679, 1'b0, {4'b1010, 3'h0, 3'h5});
        make(32'h1234_5679, hi(1, 1, 0, 1, 0, 3'h7, 3'h0, 16'h5566));
        look(48'h5566_1234_5679, 1'b1, {4'b1100, 3'h0, 3'h1});
        make(32'h1234_5679, hi(0, 0, 0, 0, 0, 3'h0, 3'h0, 16'h5566));
        look(48'h5566_1234_5679, 1'b1, 10'h000);
    endtask

    // Every port code
    task automatic t_ports;
        for (int c = 0; c < 8; c++) begin
            make(32'h0000_0100, hi(1, 0, 1, 0, 0, 3'h0, 3'(c), 16'h0002));
            look(48'h0002_0000_0100, 1'b0, {4'b1000, 3'h0, PMASK[c]});
        end
        make(32'h0000_0100, hi(0, 0, 1, 0, 0, 3'h0, 3'h0, 16'h0002));
    endtask

    // Walk two entries with get-first and get-next past the end
    task automatic t_walk;
        logic [31:0] lo, h;
        make(32'h0000_0010, hi(1, 0, 1, 1, 0, 3'h2, 3'h1, 16'h00B0));
        make(32'h0000_0020, hi(1, 0, 1, 0, 1, 3'h6, 3'h6, 16'h00C0));
        cmd_get(32'h0000_0002, lo, h);
        `CHK("first low", 32'h0000_0010, lo)
        `CHK("first high", hi(1, 0, 1, 1, 0, 3'h2, 3'h1, 16'h00B0), h)
        cmd_get(32'h0000_0001, lo, h);
        `CHK("next low", 32'h0000_0020, lo)
        `CHK("next high", hi(1, 0, 1, 0, 1, 3'h6, 3'h6, 16'h00C0), h)
        cmd_get(32'h0000_0001, lo, h);
        `CHK("past end flags", 2'b01, h[26:25])
    endtask

    // Learned entry ages out, static entry survives and ignores learning
    task automatic t_age;
        learn(48'h0000_0000_0D00, 2'h2);
        repeat (15) @(negedge clk);
        look(48'h0000_0000_0D00, 1'b0, {4'b1000, 3'h0, 3'h4});
        learn(48'h00B0_0000_0010, 2'h2);
        repeat (45) @(negedge clk);
        look(48'h0000_0000_0D00, 1'b0, 10'h000);
        look(48'h00B0_0000_0010, 1'b0, {4'b1100, 3'h0, 3'h2});
    endtask

    // Reset, then the scenarios
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; learn_v = 1'b0; lk_v = 1'b0; dahp = 1'b0;
        addr = 16'h0000; wdata = ZERO_WORD; learn_a = 48'h0; lk_a = 48'h0; learn_p = 2'h0;
        repeat (16) @(posedge clk);
        @(negedge clk); rst = 1'b0;
        t_regs();
        t_make();
        t_ports();
        t_walk();
        t_age();
        test_done();
    end
endmodule // test_mac_table_regs
